//--- core/dss_pkg.sv
// Constants shared by both ends of the dual-select sensor serial port.
// Assumes a 20 MHz system clock on both ends and one link between them.
package dss_pkg;
	// System clock rate and the automatic temperature conversion period.
	localparam int CLK_FREQ_MHZ   = 20;
	localparam int TEMP_PERIOD_US = 350;
	localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_US * CLK_FREQ_MHZ;
	// Frame and word sizes.
	localparam int FRAME_CLKS = 16;
	localparam int CNT_W      = 5;
	localparam int ACC_W      = 12;
	localparam int ACC_SR_W   = ACC_W + 3;
	localparam int TEMP_W     = 10;
	localparam int TEMP_BITS  = TEMP_W + 1;
	localparam int CTRL_W     = 8;
	localparam int ACC_SAMPLE_RISE = 2;
	// Acceleration control word layout.
	localparam int CTRL_AXIS_BIT = 3;
	localparam int CTRL_PM_BIT   = 0;
	localparam logic [7:0] CTRL_ZERO_MASK = 8'h72;
	localparam logic [7:0] CTRL_ONE_MASK  = 8'h04;
	localparam logic [7:0] CTRL_RESET     = 8'h04;
	// Idle levels of the synchronised pins {sclk, cs_n, temp_select_n, sdi}.
	localparam logic [3:0] SYNC_IDLE = 4'h6;
	// Host serial clock half period in system clocks.
	localparam int SCLK_HALF_DIV = 10;
	// Host register map, byte addresses.
	localparam int WB_AW = 4;
	localparam logic [3:0] ADDR_CMD       = 4'h0;
	localparam logic [3:0] ADDR_ACC_CTRL  = 4'h4;
	localparam logic [3:0] ADDR_ACC_DATA  = 4'h8;
	localparam logic [3:0] ADDR_TEMP_DATA = 4'hC;
	localparam int CMD_ACC_BIT  = 0;
	localparam int CMD_TEMP_BIT = 1;
endpackage

//--- core/dss_link_if.sv
// Serial link between the sensor port and its host controller.
// Assumes the bench drives no pin itself; it resolves the shared data line here.
`timescale 1ns/1ns
interface dss_link_if;
	logic sclk;
	logic cs_n;
	logic temp_select_n;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	// Level seen on the shared data line. A released line reads as the
	// inverse of the last bit, so a sample taken too late shows as bad data.
	wire  sdo_line = sdo_oe ? sdo : ~sdo;

	modport device (
		input  sclk,
		input  cs_n,
		input  temp_select_n,
		input  sdi,
		output sdo,
		output sdo_oe
	);
	modport host (
		output sclk,
		output cs_n,
		output temp_select_n,
		output sdi,
		input  sdo_line
	);
endinterface

//--- core/dss_device.sv
// Device end of the sensor serial port: control register, acceleration
// frames and temperature frames, all clocked by the system clock.
// Assumes every link pin is asynchronous; each passes two flip-flops.
`timescale 1ns/1ns
module dss_device #(
	parameter int TEMP_PERIOD = dss_pkg::TEMP_PERIOD_CYC
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	dss_link_if.device                      link,
	input  wire logic [dss_pkg::ACC_W-1:0]  accel_x_i,
	input  wire logic [dss_pkg::ACC_W-1:0]  accel_y_i,
	input  wire logic [dss_pkg::TEMP_W-1:0] temp_i,
	output logic      [dss_pkg::CTRL_W-1:0] ctrl_o,
	output logic                            shutdown_o
);
	import dss_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection.

	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [3:0] prev_q;

	// Two flip-flops per pin, then one more stage for edge detection.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_q <= SYNC_IDLE;
			sync2_q <= SYNC_IDLE;
			prev_q  <= SYNC_IDLE;
		end
		else
		begin
			sync1_q <= {link.sclk, link.cs_n, link.temp_select_n, link.sdi};
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	wire sclk_rise = sync2_q[3] & ~prev_q[3];
	wire sclk_fall = ~sync2_q[3] & prev_q[3];
	wire cs_act    = ~sync2_q[2];
	wire cs_fall   = ~sync2_q[2] & prev_q[2];
	wire tcs_act   = ~sync2_q[1];
	wire tcs_fall  = ~sync2_q[1] & prev_q[1];
	wire tcs_rise  = sync2_q[1] & ~prev_q[1];
	wire sdi_bit   = sync2_q[0];

	////////////////////////////////////////////////////////////////////
	// Acceleration frame counter and control register.

	logic [CNT_W-1:0]  rise_cnt_q;
	logic [CTRL_W-1:0] ctrl_sr_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic              shutdown_q;

	// Serial clock edges count only inside an acceleration frame.
	wire acc_rise  = cs_act & ~cs_fall & sclk_rise;
	wire acc_fall  = cs_act & ~cs_fall & sclk_fall;
	wire last_rise = acc_rise && rise_cnt_q == CNT_W'(FRAME_CLKS - 1);
	wire in_ctrl   = acc_rise && rise_cnt_q < CNT_W'(CTRL_W);
	wire commit    = acc_rise && rise_cnt_q == CNT_W'(CTRL_W - 1);
	wire sample    = acc_rise && rise_cnt_q == CNT_W'(ACC_SAMPLE_RISE - 1);
	wire [CTRL_W-1:0] new_word = {ctrl_sr_q[CTRL_W-2:0], sdi_bit};

	// Counts serial clock rises; wraps after sixteen for the next frame.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rise_cnt_q <= '0;
		else if (cs_fall)
			rise_cnt_q <= '0;
		else if (last_rise)
			rise_cnt_q <= '0;
		else if (acc_rise)
			rise_cnt_q <= rise_cnt_q + CNT_W'(1);
	end

	// Shifts the control word in on the first eight rises of a frame.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_sr_q <= '0;
		else if (in_ctrl)
			ctrl_sr_q <= new_word;
	end

	// The word is stored at the eighth rise and kept through shutdown.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_q <= CTRL_RESET;
		else if (commit)
			ctrl_q <= new_word;
	end

	// Shutdown starts at once; wake-up waits for the sixteenth rise.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			shutdown_q <= 1'b0;
		else if (commit && new_word[CTRL_PM_BIT])
			shutdown_q <= 1'b1;
		else if (last_rise && !ctrl_q[CTRL_PM_BIT])
			shutdown_q <= 1'b0;
	end

	assign ctrl_o     = ctrl_q;
	assign shutdown_o = shutdown_q;

	////////////////////////////////////////////////////////////////////
	// Acceleration sample and result shifter.

	logic [ACC_SR_W-1:0] acc_sr_q;

	// The axis bit routes X or Y; a powered-down converter returns zero.
	wire [ACC_W-1:0] acc_pick = ctrl_q[CTRL_AXIS_BIT] ? accel_y_i : accel_x_i;
	wire [ACC_W-1:0] acc_word = shutdown_q ? '0 : acc_pick;

	// Loaded on the second rise, shifted one bit per fall.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			acc_sr_q <= '0;
		else if (cs_fall)
			acc_sr_q <= '0;
		else if (sample)
			acc_sr_q <= {1'b0, acc_word, 2'b00};
		else if (acc_fall)
			acc_sr_q <= {acc_sr_q[ACC_SR_W-2:0], 1'b0};
	end

	////////////////////////////////////////////////////////////////////
	// Temperature conversion timer and result register.

	logic [$clog2(TEMP_PERIOD)-1:0] timer_q;
	logic [TEMP_W-1:0]              temp_res_q;

	wire timer_end = timer_q == ($clog2(TEMP_PERIOD))'(TEMP_PERIOD - 1);

	// Free-running period, restarted when a temperature read ends.
	always_ff @(posedge clk_i)
	begin
		if (rst_i || tcs_rise || timer_end)
			timer_q <= '0;
		else
			timer_q <= timer_q + 1'b1;
	end

	// A conversion lands only when no read is in progress, so a frame
	// never sees its result change underneath it.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			temp_res_q <= '0;
		else if (timer_end && !tcs_act)
			temp_res_q <= temp_i;
	end

	////////////////////////////////////////////////////////////////////
	// Temperature read shifter.

	logic [TEMP_BITS-1:0] tsr_q;
	logic [3:0]           tshift_q;

	// Falls while deselected are ignored; once all bits are out the last
	// one stays on the line.
	wire tmp_fall = tcs_act & ~tcs_fall & sclk_fall;
	wire tmp_more = tshift_q < 4'(TEMP_BITS - 1);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tsr_q    <= '0;
			tshift_q <= '0;
		end
		else if (tcs_fall)
		begin
			tsr_q    <= {1'b0, temp_res_q};
			tshift_q <= '0;
		end
		else if (tmp_fall && tmp_more)
		begin
			tsr_q    <= {tsr_q[TEMP_BITS-2:0], 1'b0};
			tshift_q <= tshift_q + 4'(1);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Serial output and its enable.

	logic sdo_q;
	logic oe_q;
	logic sdo_d;

	// Picks the bit for the line from whichever frame is open.
	always_comb
	begin
		sdo_d = sdo_q;
		if (tcs_act)
			sdo_d = tsr_q[TEMP_BITS-1];
		else if (cs_fall)
			sdo_d = 1'b0;
		else if (acc_fall)
			sdo_d = acc_sr_q[ACC_SR_W-1];
	end

	// The line is driven only while a select is low.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sdo_q <= 1'b0;
			oe_q  <= 1'b0;
		end
		else
		begin
			sdo_q <= sdo_d;
			oe_q  <= cs_act | tcs_act;
		end
	end

	assign link.sdo    = sdo_q;
	assign link.sdo_oe = oe_q;
endmodule

//--- core/dss_host.sv
// Host end: runs acceleration and temperature frames on the link as
// ordered through its own registers on a classic Wishbone slave port.
// Assumes the device answers on the shared data line; that line is
// asynchronous and passes two flip-flops.
`timescale 1ns/1ns
module dss_host #(
	parameter int HALF_DIV = dss_pkg::SCLK_HALF_DIV
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [dss_pkg::WB_AW-1:0] wb_adr_i,
	input  wire logic [31:0]               wb_dat_i,
	input  wire logic [3:0]                wb_sel_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	dss_link_if.host                       link
);
	import dss_pkg::*;

	typedef enum logic [2:0] {IDLE, LOW, HIGH, TAIL, GAP} dss_state_t;

	////////////////////////////////////////////////////////////////////
	// Register bus.

	logic        ack_q;
	logic [31:0] dat_q;
	logic [7:0]  acc_ctrl_q;
	logic [15:0] acc_data_q;
	logic [15:0] temp_data_q;
	dss_state_t  state_q;

	wire req      = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr_lo    = req & wb_we_i & wb_sel_i[0];
	wire busy     = state_q != IDLE;
	wire start_ok = wr_lo && wb_adr_i == ADDR_CMD && !busy;
	wire go_acc   = start_ok & wb_dat_i[CMD_ACC_BIT];
	// A command naming both frames runs only the acceleration frame.
	wire go_temp  = start_ok & wb_dat_i[CMD_TEMP_BIT] & ~wb_dat_i[CMD_ACC_BIT];

	wire [31:0] rd_mux =
		(wb_adr_i == ADDR_CMD)       ? {31'h0, busy} :
		(wb_adr_i == ADDR_ACC_CTRL)  ? {24'h0, acc_ctrl_q} :
		(wb_adr_i == ADDR_ACC_DATA)  ? {16'h0, acc_data_q} :
		(wb_adr_i == ADDR_TEMP_DATA) ? {16'h0, temp_data_q} : 32'h0;

	// One-cycle acknowledge with registered read data.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end
		else
		begin
			ack_q <= req;
			dat_q <= req ? rd_mux : dat_q;
		end
	end

	// Control word that the next acceleration frame sends.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			acc_ctrl_q <= CTRL_RESET;
		else if (wr_lo && wb_adr_i == ADDR_ACC_CTRL)
			acc_ctrl_q <= wb_dat_i[7:0];
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	////////////////////////////////////////////////////////////////////
	// Serial clock divider and frame sequencer.

	logic [$clog2(HALF_DIV)-1:0] div_q;
	logic [3:0]  bit_q;
	logic        temp_q;
	logic        cs_n_q;
	logic        tcs_n_q;
	logic        sclk_q;
	logic [7:0]  tx_q;
	logic [15:0] rx_q;
	logic        sdo_s1_q;
	logic        sdo_s2_q;

	wire tick = div_q == ($clog2(HALF_DIV))'(HALF_DIV - 1);
	// Fixed control bits are forced so software cannot break the word.
	wire [7:0] tx_word = (acc_ctrl_q & ~CTRL_ZERO_MASK) | CTRL_ONE_MASK;

	// Half-period divider, restarted with every frame.
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state_q == IDLE || tick)
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end

	// Two flip-flops on the returned data line.
	always_ff @(posedge clk_i)
	begin
		sdo_s1_q <= link.sdo_line;
		sdo_s2_q <= sdo_s1_q;
	end

	// Sixteen clocks per frame, data captured on every rise.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= IDLE;
			cs_n_q  <= 1'b1;
			tcs_n_q <= 1'b1;
			sclk_q  <= 1'b0;
			bit_q   <= '0;
			temp_q  <= 1'b0;
			tx_q    <= '0;
			rx_q    <= '0;
			acc_data_q  <= '0;
			temp_data_q <= '0;
		end
		else
		begin
			case (state_q)
				IDLE:
				begin
					bit_q  <= '0;
					temp_q <= go_temp;
					tx_q   <= go_temp ? 8'h00 : tx_word;
					if (go_acc || go_temp)
					begin
						cs_n_q  <= ~go_acc;
						tcs_n_q <= ~go_temp;
						state_q <= LOW;
					end
				end
				LOW:
					if (tick)
					begin
						sclk_q  <= 1'b1;
						rx_q    <= {rx_q[14:0], sdo_s2_q};
						state_q <= HIGH;
					end
				HIGH:
					if (tick)
					begin
						sclk_q  <= 1'b0;
						tx_q    <= {tx_q[6:0], 1'b0};
						bit_q   <= bit_q + 4'(1);
						state_q <= (bit_q == 4'(FRAME_CLKS - 1)) ? TAIL : LOW;
					end
				TAIL:
					if (tick)
					begin
						cs_n_q  <= 1'b1;
						tcs_n_q <= 1'b1;
						if (temp_q)
							temp_data_q <= rx_q;
						else
							acc_data_q <= rx_q;
						state_q <= GAP;
					end
				GAP:
					if (tick)
						state_q <= IDLE;
				default:
					state_q <= IDLE;
			endcase
		end
	end

	assign link.sclk          = sclk_q;
	assign link.cs_n          = cs_n_q;
	assign link.temp_select_n = tcs_n_q;
	assign link.sdi           = tx_q[7];
endmodule

//--- verification/dss_link_properties.sv
// Checker for the serial link between the host and device ends.
// Assumes it sees the interface signals and the host's system clock.
`timescale 1ns/1ns
module dss_link_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic temp_select_n,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic [4:0] rises_q;
	logic       sclk_q;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////////////////
	// Counts serial clock rises while either select is low.
	always_ff @(posedge clk_i)
	begin
		sclk_q <= sclk;
		if (rst_i || (cs_n && temp_select_n))
			rises_q <= 5'h00;
		else if (sclk && !sclk_q)
			rises_q <= rises_q + 5'h01;
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// A driven line is let go within a few cycles.
	sequence s_release;
		sdo_oe ##[1:5] !sdo_oe;
	endsequence

	// Link timing and framing relations.
	AST_OE_ON: assert property ($fell(cs_n && temp_select_n) |-> ##[1:5] sdo_oe)
		else $error("Data line not driven after a select fell.");
	AST_ACC_REL: assert property ($rose(cs_n) |-> s_release)
		else $error("Data line not released after the frame.");
	AST_TEMP_HOLD: assert property ($rose(temp_select_n) |-> $stable(sdo) ##0 s_release)
		else $error("Last temperature bit not held, or line not released.");
	AST_IDLE: assert property ((cs_n && temp_select_n) [*6] |-> !sdo_oe)
		else $error("Data line driven with no select low.");
	AST_SHIFT_EDGE: assert property (sclk [*5] |-> $stable(sdo))
		else $error("Data out changed while the serial clock was high.");
	AST_TAKE_EDGE: assert property ($rose(sclk) |-> $stable(sdi))
		else $error("Data in changed at a serial clock rise.");
	AST_ONE_SELECT: assert property (!cs_n |-> temp_select_n)
		else $error("Both selects low together.");
	AST_FRAME_LEN: assert property (($rose(cs_n) || $rose(temp_select_n)) |-> rises_q == 5'h10)
		else $error("Frame did not carry sixteen serial clock rises.");
	AST_TEMP_IN_LOW: assert property (!temp_select_n |-> !sdi)
		else $error("Data in high during a temperature frame.");
endmodule

//--- verification/dual_select_sensor_serial_port_tb.sv
// Testbench joining host and device ends over the link interface.
// Assumes a 20 MHz clock; registers are reached over classic Wishbone.
`timescale 1ns/1ns
module dual_select_sensor_serial_port_tb;
	import dss_pkg::*;
	localparam int TEMP_PER = 200;
	// Idle cycles before each acceleration frame: 100 us keeps sampling at 10 kSPS or less.
	localparam int ACC_GAP  = 2000;
	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [3:0]  wb_adr;
	logic [31:0] wb_dat_w;
	logic [31:0] wb_dat_r;
	logic        wb_ack;
	logic [11:0] accel_x;
	logic [11:0] accel_y;
	logic [9:0]  temp;
	logic [7:0]  ctrl;
	logic        shutdown;
	logic [31:0] rd;
	int          failures;
	int          checked;

	////////////////////////////////////////////////////////////////////////////////////////
	// Both ends, the link between them and its checker.
	dss_link_if link ();
	dss_host u_dss_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w), .wb_sel_i(4'hF),
		.wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .link(link));
	dss_device #(.TEMP_PERIOD(TEMP_PER)) u_dss_device (.clk_i(clk_i), .rst_i(rst_i),
		.link(link), .accel_x_i(accel_x), .accel_y_i(accel_y), .temp_i(temp),
		.ctrl_o(ctrl), .shutdown_o(shutdown));
	dss_link_props u_props (.clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk), .cs_n(link.cs_n),
		.temp_select_n(link.temp_select_n), .sdi(link.sdi), .sdo(link.sdo),
		.sdo_oe(link.sdo_oe));

	////////////////////////////////////////////////////////////////////////////////////////
	// Prints the verdict and stops the run.
	task automatic end_of_test();
		if (failures == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Compares a value with its expectation and reports a mismatch.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One classic Wishbone cycle; holds the request until ack is seen.
	// Only the watchdog ends a wait for an acknowledge that never comes.
	task automatic wb_cycle(input logic we, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		do
		begin
			@(posedge clk_i);
		end while (wb_ack !== 1'b1);
		r = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	// Starts a frame, polls busy until it clears, then reads a result register.
	task automatic run_frame(input logic [31:0] cmd, input logic [3:0] a);
		wb_cycle(1'b1, ADDR_CMD, cmd, rd);
		do
		begin
			wb_cycle(1'b0, ADDR_CMD, 32'h0, rd);
		end while (rd[0] !== 1'b0);
		wb_cycle(1'b0, a, 32'h0, rd);
	endtask

	// Writes the control word and runs one acceleration frame.
	task automatic run_accel(input logic [7:0] word);
		repeat (ACC_GAP) @(posedge clk_i);
		wb_cycle(1'b1, ADDR_ACC_CTRL, {24'h0, word}, rd);
		run_frame(32'h1, ADDR_ACC_DATA);
	endtask

	////////////////////////////////////////////////////////////////////////////////////////
	// Clock and a watchdog that cuts a hang short.
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		failures++;
		end_of_test();
	end

	// Main sequence of scenarios.
	initial
	begin
		failures = 0;
		checked = 0;
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 4'h0;
		wb_dat_w = 32'h0;
		accel_x = 12'hA5C;
		accel_y = 12'h3C1;
		temp = 10'h360;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		check({31'h0, link.sdo_oe}, 32'h0);
		check({24'h0, ctrl}, 32'h04);
		wb_cycle(1'b0, 4'h2, 32'h0, rd);
		check(rd, 32'h0);
		wb_cycle(1'b0, ADDR_ACC_CTRL, 32'h0, rd);
		check(rd, 32'h04);
		// Shutdown word with fixed bits forced; this frame still samples X.
		run_accel(8'hFF);
		check(rd, {16'h0, 3'b000, accel_x, 1'b0});
		check({24'h0, ctrl}, 32'h8D);
		check({31'h0, shutdown}, 32'h1);
		// Frame run in shutdown returns zeros and wakes on its last rise.
		run_accel(8'h08);
		check(rd, 32'h0);
		check({24'h0, ctrl}, 32'h0C);
		check({31'h0, shutdown}, 32'h0);
		run_accel(8'h08);
		check(rd, {16'h0, 3'b000, accel_y, 1'b0});
		// Temperature frames: leading zero, result, last bit held.
		run_frame(32'h2, ADDR_TEMP_DATA);
		check(rd, {16'h0, 1'b0, temp, {5{temp[0]}}});
		temp <= 10'h3FF;
		repeat (TEMP_PER + 100) @(posedge clk_i);
		run_frame(32'h2, ADDR_TEMP_DATA);
		check(rd, {16'h0, 1'b0, 10'h3FF, 5'h1F});
		temp <= 10'h064;
		run_frame(32'h2, ADDR_TEMP_DATA);
		check(rd, {16'h0, 1'b0, 10'h3FF, 5'h1F});
		check({31'h0, link.sdo_oe}, 32'h0);
		end_of_test();
	end
endmodule
